// ---- core/smh_pkg.sv ----
package smh_pkg;

  // *********************************
  // bus map (register indices, byte address bits 4:2)
  // *********************************
  localparam int unsigned ADDR_W          = 5;
  localparam int unsigned DATA_W          = 32;
  localparam logic [2:0]  IDX_MODEM_STAT  = 3'h0;
  localparam logic [2:0]  IDX_MODEM_CTRL  = 3'h1;
  localparam logic [2:0]  IDX_INT_ENABLE  = 3'h2;
  localparam logic [2:0]  IDX_EVT_STATUS  = 3'h3;
  localparam logic [2:0]  IDX_EVT_MASK    = 3'h4;

  // *********************************
  // modem inputs, in change-flag order
  // *********************************
  localparam int unsigned NUM_IN          = 4;
  localparam int unsigned IN_CTS          = 0;
  localparam int unsigned IN_DSR          = 1;
  localparam int unsigned IN_RI           = 2;
  localparam int unsigned IN_DCD          = 3;

  // *********************************
  // field positions
  // *********************************
  localparam int unsigned MS_DELTA_LSB    = 0;
  localparam int unsigned MS_LEVEL_LSB    = 4;
  localparam int unsigned MC_DTR_BIT      = 0;
  localparam int unsigned MC_RTS_BIT      = 1;
  localparam int unsigned MC_LOOP_BIT     = 4;
  localparam int unsigned IE_MODEM_BIT    = 3;

  // *********************************
  // reset values
  // *********************************
  localparam logic [7:0]  MODEM_CTRL_RST  = 8'h00;
  localparam logic [7:0]  INT_ENABLE_RST  = 8'h00;
  localparam logic [3:0]  EVT_MASK_RST    = 4'h0;
  localparam logic [3:0]  SYNC_RST        = 4'hf;

  // *********************************
  // bus answer states
  // *********************************
  typedef enum logic [0:0] {
    SMH_BUS_IDLE = 1'b0,
    SMH_BUS_DONE = 1'b1
  } smh_bus_type;

endpackage

// ---- core/smh_sync.sv ----
`timescale 1ns/1ps
module smh_sync
(
  clk,
  rst_b,
  asyncIn,
  syncOut
);
  import smh_pkg::*;
  input  wire logic                        clk;
  input  wire logic                        rst_b;
  input  wire logic [smh_pkg::NUM_IN-1:0]  asyncIn;
  output logic      [smh_pkg::NUM_IN-1:0]  syncOut;

  logic [NUM_IN-1:0] meta_q;

  // *********************************
  // two-stage synchroniser, idle high
  // *********************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_q  <= SYNC_RST;
      syncOut <= SYNC_RST;
    end
    else
    begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule // smh_sync

// ---- core/smh_modem_handshake.sv ----
`timescale 1ns/1ps
module smh_modem_handshake
(
  clk,
  rst_b,
  address,
  read,
  write,
  writedata,
  byteenable,
  readdata,
  waitrequest,
  clear_to_send_in_n,
  data_set_ready_in_n,
  ring_indicator_in_n,
  carrier_detect_in_n,
  terminal_ready_out_n,
  request_to_send_out_n,
  irq
);
  import smh_pkg::*;
  input  wire logic                        clk;
  input  wire logic                        rst_b;
  input  wire logic [smh_pkg::ADDR_W-1:0]  address;
  input  wire logic                        read;
  input  wire logic                        write;
  input  wire logic [smh_pkg::DATA_W-1:0]  writedata;
  input  wire logic [3:0]                  byteenable;
  output logic      [smh_pkg::DATA_W-1:0]  readdata;
  output logic                             waitrequest;
  input  wire logic                        clear_to_send_in_n;
  input  wire logic                        data_set_ready_in_n;
  input  wire logic                        ring_indicator_in_n;
  input  wire logic                        carrier_detect_in_n;
  output logic                             terminal_ready_out_n;
  output logic                             request_to_send_out_n;
  output logic                             irq;

  // *********************************
  // declarations
  // *********************************
  smh_bus_type       busState_q;
  logic [NUM_IN-1:0] pinSync;
  logic [NUM_IN-1:0] pinPrev_q;
  logic [NUM_IN-1:0] pinChange;
  logic [NUM_IN-1:0] deltaSet;
  logic [NUM_IN-1:0] delta_q;
  logic [NUM_IN-1:0] evtStat_q;
  logic [NUM_IN-1:0] evtMask_q;
  logic [7:0]        modemCtrl_q;
  logic [7:0]        intEnable_q;
  logic [2:0]        regIdx;
  logic              accept;
  logic              wrDone;
  logic              rdDone;
  logic              msrDone;
  logic [NUM_IN-1:0] msrClear;
  logic              riFall_q;

  function automatic logic [DATA_W-1:0] readMux(input logic [2:0] idx,
                                                input logic [7:0] modem_status_reg,
                                                input logic [7:0] modem_control_reg,
                                                input logic [7:0] ier,
                                                input logic [3:0] est,
                                                input logic [3:0] emk);
    logic [DATA_W-1:0] v;
    v = '0;
    unique case (idx)
      IDX_MODEM_STAT: v[7:0] = modem_status_reg;
      IDX_MODEM_CTRL: v[7:0] = modem_control_reg;
      IDX_INT_ENABLE: v[7:0] = ier;
      IDX_EVT_STATUS: v[3:0] = est;
      IDX_EVT_MASK:   v[3:0] = emk;
      default:        v      = '0;
    endcase
    return v;
  endfunction

  // *********************************
  // input synchronisation and change detection
  // *********************************
  smh_sync u_sync
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn ({carrier_detect_in_n, ring_indicator_in_n,
               data_set_ready_in_n, clear_to_send_in_n}),
    .syncOut (pinSync)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pinPrev_q <= SYNC_RST;
    else
      pinPrev_q <= pinSync;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++)
    begin : g_edge
      assign pinChange[gi] = pinSync[gi] ^ pinPrev_q[gi];
      if (gi == IN_RI)
      begin : g_ri
        assign deltaSet[gi] = pinSync[gi] & ~pinPrev_q[gi];
      end
      else
      begin : g_any
        assign deltaSet[gi] = pinChange[gi];
      end
    end
  endgenerate

  // *********************************
  // avalon slave: one wait cycle per access
  // *********************************
  assign regIdx   = address[4:2];
  assign accept   = (read | write) & (busState_q == SMH_BUS_IDLE);
  assign wrDone   = write & (busState_q == SMH_BUS_DONE) & byteenable[0];
  assign rdDone   = read & (busState_q == SMH_BUS_DONE);
  assign msrDone  = rdDone & (regIdx == IDX_MODEM_STAT);
  assign msrClear = msrDone ? readdata[MS_DELTA_LSB +: NUM_IN] : '0;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      busState_q  <= SMH_BUS_IDLE;
      waitrequest <= 1'b1;
    end
    else
    begin
      unique case (busState_q)
        SMH_BUS_IDLE:
        begin
          if (accept)
          begin
            busState_q  <= SMH_BUS_DONE;
            waitrequest <= 1'b0;
          end
        end
        SMH_BUS_DONE:
        begin
          busState_q  <= SMH_BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // levels are the complement of the pins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      readdata <= '0;
    else if (accept & read)
      readdata <= readMux(regIdx, {~pinSync, delta_q}, modemCtrl_q, intEnable_q,
                          evtStat_q, evtMask_q);
  end

  // *********************************
  // change flags: set wins, clear only what was returned
  // *********************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      delta_q <= '0;
    else
      delta_q <= (delta_q & ~msrClear) | deltaSet;
  end

  // ring falling edge has no status flag but still interrupts
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      riFall_q <= 1'b0;
    else
      riFall_q <= (riFall_q & ~msrDone) | (pinPrev_q[IN_RI] & ~pinSync[IN_RI]);
  end

  // *********************************
  // control registers
  // *********************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      modemCtrl_q <= MODEM_CTRL_RST;
      intEnable_q <= INT_ENABLE_RST;
      evtMask_q   <= EVT_MASK_RST;
    end
    else if (wrDone)
    begin
      if (regIdx == IDX_MODEM_CTRL)
        modemCtrl_q <= writedata[7:0];
      if (regIdx == IDX_INT_ENABLE)
        intEnable_q <= writedata[7:0];
      if (regIdx == IDX_EVT_MASK)
        evtMask_q <= writedata[NUM_IN-1:0];
    end
  end

  // sticky per-input events, write one to clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      evtStat_q <= '0;
    else if (wrDone && regIdx == IDX_EVT_STATUS)
      evtStat_q <= (evtStat_q & ~writedata[NUM_IN-1:0]) | pinChange;
    else
      evtStat_q <= evtStat_q | pinChange;
  end

  // *********************************
  // outputs
  // *********************************
  // clear-to-send reaches nothing but status and interrupt
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= (intEnable_q[IE_MODEM_BIT] & ((|delta_q) | riFall_q))
             | (|(evtStat_q & evtMask_q));
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      terminal_ready_out_n  <= 1'b1;
      request_to_send_out_n <= 1'b1;
    end
    else
    begin
      terminal_ready_out_n  <= ~(modemCtrl_q[MC_DTR_BIT] & ~modemCtrl_q[MC_LOOP_BIT]);
      request_to_send_out_n <= ~(modemCtrl_q[MC_RTS_BIT] & ~modemCtrl_q[MC_LOOP_BIT]);
    end
  end

  // *********************************
  // assertions
  // *********************************
  sequence s_request;
    (read | write) && waitrequest;
  endsequence

  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence

  property p_busAnswer;
    @(posedge clk) disable iff (!rst_b)
    s_request |=> s_answer;
  endproperty
  a_busAnswer: assert property (p_busAnswer)
    else $error("access not answered after one wait cycle");

  property p_msLevels;
    @(posedge clk) disable iff (!rst_b)
    (accept && read && regIdx == IDX_MODEM_STAT) |=> (readdata[7:4] == ~$past(pinSync));
  endproperty
  a_msLevels: assert property (p_msLevels)
    else $error("status levels are not the inverted inputs");

  property p_ctsDelta;
    @(posedge clk) disable iff (!rst_b)
    (pinSync[IN_CTS] != pinPrev_q[IN_CTS]) |=> delta_q[IN_CTS];
  endproperty
  a_ctsDelta: assert property (p_ctsDelta)
    else $error("clear-to-send change not flagged");

  property p_dsrDelta;
    @(posedge clk) disable iff (!rst_b)
    (pinSync[IN_DSR] != pinPrev_q[IN_DSR]) |=> delta_q[IN_DSR];
  endproperty
  a_dsrDelta: assert property (p_dsrDelta)
    else $error("data-set-ready change not flagged");

  property p_riRise;
    @(posedge clk) disable iff (!rst_b)
    $rose(delta_q[IN_RI]) |-> $past(pinSync[IN_RI] & ~pinPrev_q[IN_RI]);
  endproperty
  a_riRise: assert property (p_riRise)
    else $error("ring flag set without a low-to-high edge");

  property p_riFall;
    @(posedge clk) disable iff (!rst_b)
    (pinPrev_q[IN_RI] && !pinSync[IN_RI]) |=> riFall_q;
  endproperty
  a_riFall: assert property (p_riFall)
    else $error("ring falling edge not held for the interrupt");

  property p_msClear;
    @(posedge clk) disable iff (!rst_b)
    (msrDone && deltaSet == '0) |=> ((delta_q & $past(readdata[3:0])) == '0);
  endproperty
  a_msClear: assert property (p_msClear)
    else $error("status read did not clear returned flags");

  property p_irq;
    @(posedge clk) disable iff (!rst_b)
    (intEnable_q[IE_MODEM_BIT] && ((|delta_q) || riFall_q)) |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("modem interrupt missing while flag pending");

  property p_irqCause;
    @(posedge clk) disable iff (!rst_b)
    irq |-> $past((intEnable_q[IE_MODEM_BIT] & ((|delta_q) | riFall_q)) | (|(evtStat_q & evtMask_q)));
  endproperty
  a_irqCause: assert property (p_irqCause)
    else $error("interrupt high without a cause");

  property p_dtr;
    @(posedge clk) disable iff (!rst_b)
    ##1 (terminal_ready_out_n == ~($past(modemCtrl_q[MC_DTR_BIT]) & ~$past(modemCtrl_q[MC_LOOP_BIT])));
  endproperty
  a_dtr: assert property (p_dtr)
    else $error("terminal ready does not follow control");

  property p_rts;
    @(posedge clk) disable iff (!rst_b)
    $past(modemCtrl_q[MC_LOOP_BIT]) |-> request_to_send_out_n;
  endproperty
  a_rts: assert property (p_rts)
    else $error("request-to-send active in loopback");

endmodule // smh_modem_handshake

// ---- test/smh_modem_model.sv ----
`timescale 1ns/1ps
module smh_modem_model
(
  clk,
  pinCmd,
  pinOut
);
  input  wire logic       clk;
  input  wire logic [3:0] pinCmd;
  output logic      [3:0] pinOut = 4'hf;

  logic [3:0] stage_q = 4'hf;

  // slow modem: pins follow the command two edges late, idle high, never reset by the host
  always @(posedge clk)
  begin
    stage_q <= pinCmd;
    pinOut  <= stage_q;
  end
endmodule // smh_modem_model

// ---- test/test_serial_port_modem_handshake.sv ----
`timescale 1ns/1ps
module test_serial_port_modem_handshake;
  import smh_pkg::*;
  localparam logic [4:0] MS = {IDX_MODEM_STAT, 2'b00};
  localparam logic [4:0] MC = {IDX_MODEM_CTRL, 2'b00};
  localparam logic [4:0] IE = {IDX_INT_ENABLE, 2'b00};
  localparam logic [4:0] ES = {IDX_EVT_STATUS, 2'b00};
  localparam logic [4:0] EM = {IDX_EVT_MASK, 2'b00};
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic              read = 1'b0;
  logic              write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [3:0]        byteenable = 4'hf;
  logic [DATA_W-1:0] readdata;
  logic              waitrequest;
  logic [3:0]        pinCmd = 4'hf;
  logic [3:0]        pins;
  logic              dtrN;
  logic              rtsN;
  logic              irq;
  logic [DATA_W-1:0] rd;
  logic [3:0]        prevPins;
  logic              ieOn;
  int                n_errors = 0;
  int                n_compared = 0;
  int                seed = 32'h0eb64c89;

  always #10 clk = ~clk;

  smh_modem_handshake dut_u
  (
    .clk                   (clk),
    .rst_b                 (rst_b),
    .address               (address),
    .read                  (read),
    .write                 (write),
    .writedata             (writedata),
    .byteenable            (byteenable),
    .readdata              (readdata),
    .waitrequest           (waitrequest),
    .clear_to_send_in_n    (pins[IN_CTS]),
    .data_set_ready_in_n   (pins[IN_DSR]),
    .ring_indicator_in_n   (pins[IN_RI]),
    .carrier_detect_in_n   (pins[IN_DCD]),
    .terminal_ready_out_n  (dtrN),
    .request_to_send_out_n (rtsN),
    .irq                   (irq)
  );

  smh_modem_model modem_u
  (
    .clk    (clk),
    .pinCmd (pinCmd),
    .pinOut (pins)
  );

  // ************
  // helpers
  // ************
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask

  // one bus access; entered just after a rising edge, leaves just after one
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [3:0] be);
    read       <= !w;
    write      <= w;
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rdr(input logic [ADDR_W-1:0] a);
    bus(1'b0, a, '0, 4'hf);
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // status word from pins at the last read and pins now
  function automatic logic [DATA_W-1:0] msrExp(input logic [3:0] p, input logic [3:0] c);
    logic [3:0] d;
    d = p ^ c;
    d[IN_RI] = !p[IN_RI] && c[IN_RI];
    return {24'h0, ~c, d};
  endfunction

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ************
  // tests
  // ************
  initial
  begin
    repeat (6) @(posedge clk);
    chk({irq, dtrN, rtsN, waitrequest}, 4'b0111);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      wr(MC, {27'h0, i[2], 2'b00, i[1:0]});
      waitCyc(2);
      chk(dtrN, !(i[0] && !i[2]));
      chk(rtsN, !(i[1] && !i[2]));
    end
    wr(MC, 32'h0);
    bus(1'b1, MC, 32'h3, 4'h0);
    waitCyc(2);
    chk({dtrN, rtsN}, 2'b11);
    $display("test control outputs done");
    rdr(MS);
    prevPins = 4'hf;
    for (int k = 0; k < 32; k++)
    begin
      ieOn = (k == 0) ? 1'b1 : 1'($random(seed));
      wr(IE, {28'h0, ieOn, 3'h0});
      pinCmd <= (k == 0) ? 4'b1011 : 4'($random(seed));
      waitCyc(8);
      chk(irq, ieOn && (prevPins != pinCmd));
      rdr(MS);
      chk(rd, msrExp(prevPins, pinCmd));
      prevPins = pinCmd;
      waitCyc(2);
      chk(irq, 1'b0);
      rdr(MS);
      chk(rd, {24'h0, ~pinCmd, 4'h0});
    end
    $display("test modem status done");
    wr(IE, 32'h0);
    wr(ES, 32'hf);
    rdr(ES);
    chk(rd, 32'h0);
    wr(EM, 32'h4);
    pinCmd <= pinCmd ^ 4'h4;
    waitCyc(8);
    chk(irq, 1'b1);
    rdr(ES);
    chk(rd, 32'h4);
    wr(ES, 32'h4);
    waitCyc(2);
    chk(irq, 1'b0);
    rdr(5'h1c);
    chk(rd, 32'h0);
    $display("test event interrupt done");
    wr(MC, 32'h3);
    waitCyc(2);
    chk({dtrN, rtsN}, 2'b00);
    rst_b <= 1'b0;
    waitCyc(2);
    chk({dtrN, rtsN, irq}, 3'b110);
    rst_b <= 1'b1;
    waitCyc(2);
    chk({dtrN, rtsN, irq}, 3'b110);
    rdr(MC);
    chk(rd, 32'h0);
    $display("test mid reset done");
    summarize();
  end

  initial
  begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule // test_serial_port_modem_handshake
